// File: common/bcc_pkg.sv
`default_nettype none
package bcc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_ALRM  = 8'h04;
  localparam logic [7:0] ADDR_TIME  = 8'h08;
  localparam logic [7:0] ADDR_DATE  = 8'h0C;
  localparam logic [7:0] ADDR_ATIME = 8'h10;
  localparam logic [7:0] ADDR_ADATE = 8'h14;
  localparam logic [7:0] ADDR_PRIO  = 8'h18;
  // ==========================================================
  // field positions
  localparam int CTRL_ON    = 15;
  localparam int CTRL_FRZ   = 14;
  localparam int CTRL_RUN   = 6;
  localparam int CTRL_WREN  = 3;
  localparam int CTRL_SYNC  = 2;
  localparam int CTRL_HALF  = 1;
  localparam int ALRM_EN    = 15;
  localparam int ALRM_CHIME = 14;
  localparam int ALRM_PIV   = 13;
  localparam int PRIO_LSB   = 26;
  localparam int SUB_LSB    = 24;
  localparam int HALF_BIT   = 14;
  // ==========================================================
  // reset values and counting limits
  localparam logic [31:0] TIME_RST   = 32'h0000_0000;
  localparam logic [31:0] DATE_RST   = 32'h0001_0106;
  localparam logic [14:0] PRESC_SYNC = 15'h7FE0;
  localparam logic [14:0] PRESC_HALF = 15'h3FFF;
  localparam logic [14:0] PRESC_LAST = 15'h7FFF;
  localparam logic [14:0] PRESC_ZERO = 15'h0000;
  localparam logic [7:0]  SEC_LAST   = 8'h59;
  localparam logic [7:0]  HR_LAST    = 8'h23;
  localparam logic [7:0]  MON_LAST   = 8'h12;
  localparam logic [7:0]  YR_LAST    = 8'h99;
  localparam logic [7:0]  FIRST_ONE  = 8'h01;
  localparam logic [3:0]  WDAY_LAST  = 4'h6;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // ==========================================================
  // alarm interval select
  typedef enum logic [3:0] {
    BCC_AM_HALF  = 4'h0, BCC_AM_SEC   = 4'h1, BCC_AM_SEC10 = 4'h2,
    BCC_AM_MIN   = 4'h3, BCC_AM_MIN10 = 4'h4, BCC_AM_HOUR  = 4'h5,
    BCC_AM_DAY   = 4'h6, BCC_AM_WEEK  = 4'h7, BCC_AM_MONTH = 4'h8,
    BCC_AM_YEAR  = 4'h9
  } bcc_amask_e;
endpackage : bcc_pkg
`default_nettype wire

// File: hdl/bcc_core.sv
// Behaviour
// - priority field bits 28:26; 111 is level 7, 000 disables clock irq
// - subpriority field bits 25:24; 11 highest, 00 lowest
// - calendar 2000 to 2099, hours in 24-hour form only
// - time and date held as BCD, one digit per nibble
// - alarm interval half second to one year; half second only subsecond
// - alarm repeats at its interval; chime repeats forever
// - every alarm match toggles pulse output; raises event only when priority is not 000
// - pulse output synchronous; idle level from bit 13 of alarm control
// - seconds come from prescaling the 32.768 kHz slow clock
// - 23:59:59 rolls to 00:00:00 and carries into day
// - day carries into month after that month's last day
// - past December 31 go to January 1 and carry into year
// - weekday counts 0 to 6, wraps without carry
// - low BCD digits carry at ten, never sixteen
// - year divisible by four gives February 29 days
// - all time and date counters writable, prescaler only cleared; counting resumes from written values
// - a seconds write clears the prescaler
// - half-second status read only, cleared at each seconds rollover and by seconds write
// - safe flag high 32 edges before update, low one after, 33 total
// - time write during rollover with slow clock high is dropped
// - safe flag set at prescaler 7FE0; cleared by reset, off, seconds write, 0
// - counting stops when off or frozen in debug; bus still works
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module bcc_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              slow_clk,
  input  wire logic              debug_mode,
  output logic                   alarm_pulse,
  output logic                   clock_irq_event,
  output logic [2:0]             clock_irq_priority,
  output logic [1:0]             clock_irq_subpriority,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  if (ADDR_W < 8) begin : g_chk
    $error("bcc_core: ADDR_W must be at least 8");
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last)
      bcd_next = first;
    else if (v[3:0] == 4'h9)
      bcd_next = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_next = v + 8'h01;
  endfunction : bcd_next

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : is_leap

  // ==========================================================
  // state
  logic        ctl_on, ctl_frz, ctl_wren, run;
  logic        slow_s1, slow_s2, slow_prev;
  logic [14:0] presc;
  logic        safe_access_flag;
  logic [7:0]  sec, min, hr, day, mon, yr;
  logic [3:0]  wday;
  logic [31:0] alarm_time_reg, alarm_date_reg;
  logic        alm_en, alm_chime, pulse_initial_value;
  logic [3:0]  amask;
  logic [7:0]  alarm_repeat_count;
  logic        chk_sec, chk_half;
  logic        aw_full, w_full;
  logic [ADDR_W-1:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;

  // ==========================================================
  // slow clock sampling and prescaler controls
  wire        slow_rise  = slow_s2 & ~slow_prev;
  wire        step       = slow_rise & run;
  wire [14:0] presc_inc  = presc + 15'h0001;
  wire        next_run   = ctl_on & ~(debug_mode & ctl_frz);

  // ==========================================================
  // bus decode
  wire        wr_go     = aw_full & w_full & ~s_axi_bvalid;
  wire [7:0]  wa        = aw_q[7:0];
  wire        wa_hi0    = (aw_q >> 8) == '0;
  wire        wr_ctrl   = wr_go & wa_hi0 & (wa == bcc_pkg::ADDR_CTRL);
  wire        wr_alrm   = wr_go & wa_hi0 & (wa == bcc_pkg::ADDR_ALRM);
  wire        wr_time_r = wr_go & wa_hi0 & (wa == bcc_pkg::ADDR_TIME);
  wire        wr_date_r = wr_go & wa_hi0 & (wa == bcc_pkg::ADDR_DATE);
  wire        wr_atime  = wr_go & wa_hi0 & (wa == bcc_pkg::ADDR_ATIME);
  wire        wr_adate  = wr_go & wa_hi0 & (wa == bcc_pkg::ADDR_ADATE);
  wire        wr_prio   = wr_go & wa_hi0 & (wa == bcc_pkg::ADDR_PRIO);
  // rollover edge with slow clock still high drops the write
  wire        discard   = slow_s2 & run & (presc == bcc_pkg::PRESC_ZERO);
  wire        wr_time   = wr_time_r & ctl_wren & ~discard;
  wire        wr_date   = wr_date_r & ctl_wren & ~discard;
  wire        sec_wr    = wr_time & ws_q[1];

  // byte lane merge
  logic [31:0] lane_mask;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[8*b +: 8] = {8{ws_q[b]}};
  end

  logic [31:0] ctrl_rd, alrm_rd, prio_rd, cur_wr, rd_word;
  logic        rd_hit, wr_hit;
  wire  [31:0] time_rd = {hr, min, sec, 8'h00};
  wire  [31:0] date_rd = {yr, mon, day, 4'h0, wday};

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[bcc_pkg::CTRL_ON]   = ctl_on;
    ctrl_rd[bcc_pkg::CTRL_FRZ]  = ctl_frz;
    ctrl_rd[bcc_pkg::CTRL_RUN]  = run;
    ctrl_rd[bcc_pkg::CTRL_WREN] = ctl_wren;
    ctrl_rd[bcc_pkg::CTRL_SYNC] = safe_access_flag;
    ctrl_rd[bcc_pkg::CTRL_HALF] = presc[bcc_pkg::HALF_BIT];
    alrm_rd = '0;
    alrm_rd[bcc_pkg::ALRM_EN]    = alm_en;
    alrm_rd[bcc_pkg::ALRM_CHIME] = alm_chime;
    alrm_rd[bcc_pkg::ALRM_PIV]   = pulse_initial_value;
    alrm_rd[11:8] = amask;
    alrm_rd[7:0]  = alarm_repeat_count;
    prio_rd = '0;
    prio_rd[bcc_pkg::PRIO_LSB +: 3] = clock_irq_priority;
    prio_rd[bcc_pkg::SUB_LSB +: 2]  = clock_irq_subpriority;
  end

  function automatic logic [32:0] pick(input logic [ADDR_W-1:0] a);
    if ((a >> 8) != '0)
      pick = {1'b0, 32'h0000_0000};
    else begin
      case (a[7:0])
        bcc_pkg::ADDR_CTRL:  pick = {1'b1, ctrl_rd};
        bcc_pkg::ADDR_ALRM:  pick = {1'b1, alrm_rd};
        bcc_pkg::ADDR_TIME:  pick = {1'b1, time_rd};
        bcc_pkg::ADDR_DATE:  pick = {1'b1, date_rd};
        bcc_pkg::ADDR_ATIME: pick = {1'b1, alarm_time_reg};
        bcc_pkg::ADDR_ADATE: pick = {1'b1, alarm_date_reg};
        bcc_pkg::ADDR_PRIO:  pick = {1'b1, prio_rd};
        default:             pick = {1'b0, 32'h0000_0000};
      endcase
    end
  endfunction : pick

  assign {wr_hit, cur_wr} = pick(aw_q);
  assign {rd_hit, rd_word} = pick(s_axi_araddr);
  wire [31:0] wm = (cur_wr & ~lane_mask) | (wd_q & lane_mask);

  // ==========================================================
  // calendar carry chain
  logic [7:0] day_last;
  always_comb begin
    case (mon)
      8'h02:                      day_last = is_leap(yr) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: day_last = 8'h30;
      default:                    day_last = 8'h31;
    endcase
  end

  wire sec_tick  = step & (presc == bcc_pkg::PRESC_LAST) & ~sec_wr;
  wire half_tick = step & ((presc == bcc_pkg::PRESC_HALF) |
                           (presc == bcc_pkg::PRESC_LAST)) & ~sec_wr;
  wire c_sec = sec_tick & (sec == bcc_pkg::SEC_LAST);
  wire c_min = c_sec & (min == bcc_pkg::SEC_LAST);
  wire c_hr  = c_min & (hr == bcc_pkg::HR_LAST);
  wire c_day = c_hr & (day == day_last);
  wire c_mon = c_day & (mon == bcc_pkg::MON_LAST);
  wire [7:0] next_sec = bcd_next(sec, bcc_pkg::SEC_LAST, 8'h00);
  wire [7:0] next_min = bcd_next(min, bcc_pkg::SEC_LAST, 8'h00);
  wire [7:0] next_hr  = bcd_next(hr, bcc_pkg::HR_LAST, 8'h00);
  wire [7:0] next_day = bcd_next(day, day_last, bcc_pkg::FIRST_ONE);
  wire [7:0] next_mon = bcd_next(mon, bcc_pkg::MON_LAST, bcc_pkg::FIRST_ONE);
  wire [7:0] next_yr  = bcd_next(yr, bcc_pkg::YR_LAST, 8'h00);
  wire [3:0] next_wday = (wday == bcc_pkg::WDAY_LAST) ? 4'h0 : wday + 4'h1;

  // ==========================================================
  // alarm compare
  wire e_s01 = sec[3:0] == alarm_time_reg[11:8];
  wire e_s   = sec == alarm_time_reg[15:8];
  wire e_m01 = min[3:0] == alarm_time_reg[19:16];
  wire e_m   = min == alarm_time_reg[23:16];
  wire e_h   = hr == alarm_time_reg[31:24];
  wire e_w   = wday == alarm_date_reg[3:0];
  wire e_d   = day == alarm_date_reg[15:8];
  wire e_mo  = mon == alarm_date_reg[23:16];
  logic amatch;
  always_comb begin
    case (amask)
      bcc_pkg::BCC_AM_HALF:  amatch = chk_half;
      bcc_pkg::BCC_AM_SEC:   amatch = chk_sec;
      bcc_pkg::BCC_AM_SEC10: amatch = chk_sec & e_s01;
      bcc_pkg::BCC_AM_MIN:   amatch = chk_sec & e_s;
      bcc_pkg::BCC_AM_MIN10: amatch = chk_sec & e_s & e_m01;
      bcc_pkg::BCC_AM_HOUR:  amatch = chk_sec & e_s & e_m;
      bcc_pkg::BCC_AM_DAY:   amatch = chk_sec & e_s & e_m & e_h;
      bcc_pkg::BCC_AM_WEEK:  amatch = chk_sec & e_s & e_m & e_h & e_w;
      bcc_pkg::BCC_AM_MONTH: amatch = chk_sec & e_s & e_m & e_h & e_d;
      bcc_pkg::BCC_AM_YEAR:  amatch = chk_sec & e_s & e_m & e_h & e_d & e_mo;
      default:               amatch = 1'b0;
    endcase
  end
  wire alarm_hit = alm_en & amatch & ~wr_alrm;
  wire prio_on   = clock_irq_priority != 3'h0;

  // ==========================================================
  // slow clock, run gate, prescaler, safe flag
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_s1   <= 1'b0;
      slow_s2   <= 1'b0;
      slow_prev <= 1'b0;
      run       <= 1'b0;
    end else begin
      slow_s1   <= slow_clk;
      slow_s2   <= slow_s1;
      slow_prev <= slow_s2;
      run       <= next_run;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      presc <= bcc_pkg::PRESC_ZERO;
    else if (sec_wr)
      presc <= bcc_pkg::PRESC_ZERO;
    else if (step)
      presc <= presc_inc;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      safe_access_flag <= 1'b0;
    else if (!ctl_on || sec_wr)
      safe_access_flag <= 1'b0;
    else if (step && presc == bcc_pkg::PRESC_ZERO)
      safe_access_flag <= 1'b0;
    else if (step && presc_inc == bcc_pkg::PRESC_SYNC)
      safe_access_flag <= 1'b1;
  end

  // ==========================================================
  // time and date counters
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {hr, min, sec} <= bcc_pkg::TIME_RST[31:8];
      {yr, mon, day} <= bcc_pkg::DATE_RST[31:8];
      wday           <= bcc_pkg::DATE_RST[3:0];
    end else begin
      if (sec_tick)
        sec <= next_sec;
      if (c_sec)
        min <= next_min;
      if (c_min)
        hr <= next_hr;
      if (c_hr) begin
        day  <= next_day;
        wday <= next_wday;
      end
      if (c_day)
        mon <= next_mon;
      if (c_mon)
        yr <= next_yr;
      if (wr_time) begin
        hr  <= wm[31:24];
        min <= wm[23:16];
        sec <= wm[15:8];
      end
      if (wr_date) begin
        yr   <= wm[31:24];
        mon  <= wm[23:16];
        day  <= wm[15:8];
        wday <= wm[3:0];
      end
    end
  end

  // ==========================================================
  // control, alarm and priority registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_on    <= 1'b0;
      ctl_frz   <= 1'b0;
      ctl_wren  <= 1'b0;
      alarm_time_reg <= '0;
      alarm_date_reg <= '0;
      clock_irq_priority    <= 3'h0;
      clock_irq_subpriority <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctl_on   <= wm[bcc_pkg::CTRL_ON];
        ctl_frz  <= wm[bcc_pkg::CTRL_FRZ];
        ctl_wren <= wm[bcc_pkg::CTRL_WREN];
      end
      if (wr_atime)
        alarm_time_reg <= wm;
      if (wr_adate)
        alarm_date_reg <= wm;
      if (wr_prio) begin
        clock_irq_priority    <= wm[bcc_pkg::PRIO_LSB +: 3];
        clock_irq_subpriority <= wm[bcc_pkg::SUB_LSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alm_en              <= 1'b0;
      alm_chime           <= 1'b0;
      pulse_initial_value <= 1'b0;
      amask               <= 4'h0;
      alarm_repeat_count  <= 8'h00;
      chk_sec             <= 1'b0;
      chk_half            <= 1'b0;
      alarm_pulse         <= 1'b0;
      clock_irq_event     <= 1'b0;
    end else begin
      chk_sec  <= sec_tick;
      chk_half <= half_tick;
      clock_irq_event <= alarm_hit & prio_on;
      if (wr_alrm) begin
        alm_en              <= wm[bcc_pkg::ALRM_EN];
        alm_chime           <= wm[bcc_pkg::ALRM_CHIME];
        pulse_initial_value <= wm[bcc_pkg::ALRM_PIV];
        amask               <= wm[11:8];
        alarm_repeat_count  <= wm[7:0];
      end else if (alarm_hit) begin
        if (alarm_repeat_count == 8'h00 && !alm_chime)
          alm_en <= 1'b0;
        else
          alarm_repeat_count <= alarm_repeat_count - 8'h01;
      end
      if (!alm_en)
        alarm_pulse <= pulse_initial_value;
      else if (alarm_hit)
        alarm_pulse <= ~alarm_pulse;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_q          <= '0;
      wd_q          <= '0;
      ws_q          <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= bcc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q          <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q         <= s_axi_wdata;
        ws_q         <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLV;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full       <= 1'b0;
        w_full        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= bcc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_midnight;
    sec_tick && !wr_time && {hr, min, sec} == 24'h235959;
  endsequence
  sequence s_zero_time;
    {hr, min, sec} == 24'h000000;
  endsequence

  property p_midnight;
    s_midnight |=> s_zero_time;
  endproperty
  a_midnight: assert property (p_midnight)
    else $error("time did not roll to midnight");

  property p_digit_ten;
    sec_tick && !wr_time && sec[3:0] == 4'h9 |=> sec[3:0] == 4'h0;
  endproperty
  a_digit_ten: assert property (p_digit_ten)
    else $error("seconds low digit passed nine");

  property p_wday_wrap;
    c_hr && !wr_date && !c_day && wday == 4'h6
      |=> wday == 4'h0 && $stable(mon);
  endproperty
  a_wday_wrap: assert property (p_wday_wrap)
    else $error("weekday did not wrap to zero");

  property p_leap_feb;
    c_hr && !wr_date && mon == 8'h02 && day == 8'h28 && is_leap(yr)
      |=> day == 8'h29 && mon == 8'h02;
  endproperty
  a_leap_feb: assert property (p_leap_feb)
    else $error("leap February ended early");

  property p_year_wrap;
    c_mon && !wr_date && yr == 8'h99 |=> yr == 8'h00 && mon == 8'h01;
  endproperty
  a_year_wrap: assert property (p_year_wrap)
    else $error("year did not wrap");

  property p_sec_write;
    sec_wr |=> presc == 15'h0000 && !safe_access_flag
               && !ctrl_rd[bcc_pkg::CTRL_HALF];
  endproperty
  a_sec_write: assert property (p_sec_write)
    else $error("seconds write left prescaler running");

  property p_sync_set;
    step && ctl_on && !sec_wr && presc == 15'h7FDF |=> safe_access_flag;
  endproperty
  a_sync_set: assert property (p_sync_set)
    else $error("safe flag not set at 7FE0");

  property p_toggle;
    alarm_hit |=> alarm_pulse != $past(alarm_pulse);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("alarm pulse did not toggle");

  property p_irq_gate;
    alarm_hit |=> clock_irq_event == (clock_irq_priority != 3'h0);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("clock irq event wrong for priority");

  property p_discard;
    wr_time_r && discard && !sec_tick |=> $stable({hr, min, sec});
  endproperty
  a_discard: assert property (p_discard)
    else $error("write during rollover was taken");
endmodule : bcc_core
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        slow_clk = 1'b0;
  logic        debug_mode = 1'b0, pulse_at_irq = 1'b0;
  logic        alarm_pulse, clock_irq_event, awready, wready, bvalid;
  logic        arready, rvalid;
  logic [2:0]  clock_irq_priority;
  logic [1:0]  clock_irq_subpriority, bresp, rresp, resp;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  int          error_cnt = 0, check_count = 0, irq_n = 0;

  bcc_core i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .slow_clk(slow_clk), .debug_mode(debug_mode), .alarm_pulse(alarm_pulse),
    .clock_irq_event(clock_irq_event),
    .clock_irq_priority(clock_irq_priority),
    .clock_irq_subpriority(clock_irq_subpriority),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================
  // clocks and event counter
  always #5 core_clk = ~core_clk;
  // slow clock as fast as the synchroniser allows, one rising edge per two cycles
  always @(posedge core_clk) slow_clk <= ~slow_clk;
  always @(negedge core_clk) begin
    if (clock_irq_event === 1'b1) begin
      irq_n++;
      pulse_at_irq = alarm_pulse;
    end
  end

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    int   n;
    n = 0;
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge core_clk);
      ra = awready;
      rw = wready;
      rb = bvalid;
      resp = bresp;
      @(posedge core_clk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
      n++;
    end while (rb !== 1'b1 && n < 1000);
    bready <= 1'b0;
    chk("write answer", 32'h1, 32'(rb));
    if (rb !== 1'b1) print_verdict();
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    logic ra, rb;
    int   n;
    n = 0;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge core_clk);
      ra = arready;
      rb = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge core_clk);
      if (ra) arvalid <= 1'b0;
      n++;
    end while (rb !== 1'b1 && n < 1000);
    rready <= 1'b0;
    chk("read answer", 32'h1, 32'(rb));
    if (rb !== 1'b1) print_verdict();
  endtask : rd_reg

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_sync(input logic v);
    int n;
    n = 0;
    do begin
      rd_reg(bcc_pkg::ADDR_CTRL);
      n++;
    end while (rd[2] !== v && n < 40000);
    chk("sync wait", 32'(v), 32'(rd[2]));
    if (rd[2] !== v) print_verdict();
  endtask : wait_sync

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd_reg(bcc_pkg::ADDR_DATE);
    chk("date reset", bcc_pkg::DATE_RST, rd);
    wr(bcc_pkg::ADDR_PRIO, 32'hFFFF_FFFF);
    rd_reg(bcc_pkg::ADDR_PRIO);
    chk("prio reg", 32'h1F00_0000, rd);
    chk("prio", 32'(3'h7), 32'(clock_irq_priority));
    chk("subprio", 32'(2'h3), 32'(clock_irq_subpriority));
    wr(bcc_pkg::ADDR_PRIO, 32'h0000_0000);
    chk("prio off", 32'(3'h0), 32'(clock_irq_priority));
    rd_reg(8'h1C);
    chk("unmapped resp", 32'(bcc_pkg::RESP_SLV), 32'(resp));
    wr(bcc_pkg::ADDR_ALRM, 32'h0000_2000);
    @(negedge core_clk);
    chk("pulse idle", 32'(1'b1), 32'(alarm_pulse));
    wr(bcc_pkg::ADDR_ALRM, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_roll();
    wr(bcc_pkg::ADDR_CTRL, 32'h0000_0008);
    wr(bcc_pkg::ADDR_TIME, 32'h2359_5900);
    wr(bcc_pkg::ADDR_DATE, 32'h0002_2806);
    wr(bcc_pkg::ADDR_PRIO, 32'h1C00_0000);
    wr(bcc_pkg::ADDR_ALRM, 32'h0000_8100);
    wr(bcc_pkg::ADDR_CTRL, 32'h0000_8008);
    wait_sync(1'b1);
    chk("half at sync", 32'(1'b1), 32'(rd[1]));
    rd_reg(bcc_pkg::ADDR_TIME);
    chk("time pre", 32'h2359_5900, rd);
    wait_sync(1'b0);
    rd_reg(bcc_pkg::ADDR_TIME);
    chk("time roll", 32'h0000_0000, rd);
    rd_reg(bcc_pkg::ADDR_DATE);
    chk("date roll", 32'h0002_2900, rd);
    chk("pulse at event", 32'(1'b1), 32'(pulse_at_irq));
    chk("pulse after off", 32'(1'b0), 32'(alarm_pulse));
    chk("events", 32'd1, 32'(irq_n));
    rd_reg(bcc_pkg::ADDR_ALRM);
    chk("alarm off", 32'h0, rd & 32'h0000_8000);
    wr(bcc_pkg::ADDR_TIME, 32'h0000_0500);
    rd_reg(bcc_pkg::ADDR_CTRL);
    chk("sync half", 32'h0, rd & 32'h0000_0006);
    rd_reg(bcc_pkg::ADDR_TIME);
    chk("time set", 32'h0000_0500, rd);
    debug_mode <= 1'b1;
    wr(bcc_pkg::ADDR_CTRL, 32'h0000_C008);
    rd_reg(bcc_pkg::ADDR_CTRL);
    chk("frozen", 32'h0, rd & 32'h0000_0040);
    chk("frozen ctrl", 32'h0000_C008, rd & 32'h0000_C008);
    $display("test roll done");
  endtask : t_roll

  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_roll();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
